//--- inc/sw_pkg.sv
package sw_pkg;
  // timing base
  localparam int CLK_PS = 25000;
  localparam int NIB_PS_100 = 40000;
  localparam int NIB_PS_10 = 400000;
  localparam int IPG_BITS = 96;
  localparam int IPG_NIBS = IPG_BITS / 4;
  localparam int SLOT_BITS = 512;
  localparam int SLOT_NIBS = SLOT_BITS / 4;
  localparam int QUANTUM_NIBS = SLOT_NIBS;
  localparam int MAX_COLL = 16;
  localparam int BO_LIMIT = 10;
  localparam int BO_AGGR_LIMIT = 3;
  localparam int AGE_PERIOD_S = 300;
  localparam longint PS_PER_S = 64'd1000000000000;
  localparam int SEC_CYCLES = int'(PS_PER_S / CLK_PS);
  // frame sizes and memory
  localparam int MIN_FRAME = 64;
  localparam int MAX_FRAME = 1536;
  localparam int HUGE_FRAME = 1916;
  localparam int VLAN_TAG_BYTES = 4;
  localparam int BUF_BYTES = 128;
  localparam int NUM_BUFS = 512;
  localparam int TABLE_DEPTH = 1024;
  localparam int XOFF_LEVEL = 16;
  localparam int XON_LEVEL = 64;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FWD_MASK = 8'h04;
  localparam logic [7:0] REG_MIRROR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_SMAC_LO = 8'h10;
  localparam logic [7:0] REG_SMAC_HI = 8'h14;
  localparam logic [7:0] REG_PVLAN = 8'h18;
  // field positions
  localparam int CTRL_AGE = 0;
  localparam int CTRL_AGGR = 1;
  localparam int CTRL_XDROP = 2;
  localparam int CTRL_HUGE = 3;
  localparam int CTRL_SPEED = 4;
  localparam int MIR_SRC = 0;
  localparam int MIR_DST = 4;
  localparam int MIR_IGMP = 8;
  localparam int MIR_HOST = 12;
  localparam int SHI_PORTS = 16;
  localparam int SHI_VALID = 20;
  localparam int STAT_ENTRIES = 16;
  // reset values
  localparam logic [4:0] CTRL_RST = 5'h11;
  localparam logic [3:0] FWD_MASK_RST = 4'hF;
  localparam logic [15:0] MIRROR_RST = 16'h0000;
  localparam logic [15:0] PVLAN_RST = 16'hFFFF;
endpackage

//--- src/switch_core.sv
// Summary of operation
// - address table holds 1K entries, every slot usable, no hashing
// - unknown source on good frame is learned with port and time stamp
// - full table: last entry is overwritten by the new address
// - known source on a new port moves the entry to that port
// - source hits refresh stamp; enabled aging removes entries idle 300 s
// - first port set from lookups, then masked, IGMP-redirected and mirrored into the final port set
// - frames with receive or size errors are never forwarded
// - pause frames are consumed and never forwarded
// - destination resolving to the ingress port is discarded as local
// - store-and-forward through a shared pool of 128-byte buffers
// - 96 bit times between transmit enable end and next start
// - after collision the gap runs from carrier sense drop
// - exponential or aggressive back-off; 16th collision drops if configured
// - collision past 512 bit times drops the frame without retry
// - under 64 bytes discarded; limit 1536 or 1916, plus tag
// - pause holds normal frames until timer expires; reload on new pause
// - shared buffer pool near empty asserts XOFF on ingress; XON with hysteresis
// - receive queue full asserts flow control on all ports
`timescale 1ns/1ps
module switch_core #(
  parameter int NPORTS = 4,
  parameter int TABLE_DEPTH = sw_pkg::TABLE_DEPTH,
  parameter int NUM_BUFS = sw_pkg::NUM_BUFS,
  parameter int SEC_CYCLES = sw_pkg::SEC_CYCLES,
  parameter int MAC_PORT = 0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // received frame descriptor
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire logic [1:0] rx_port_i,
  input wire logic [47:0] rx_sa_i,
  input wire logic [47:0] rx_da_i,
  input wire logic [10:0] rx_len_i,
  input wire logic rx_err_i,
  input wire logic rx_tagged_i,
  input wire logic rx_pause_i,
  input wire logic [15:0] rx_pause_time_i,
  input wire logic rx_igmp_i,
  // forwarding result
  output logic fwd_valid_o,
  output logic fwd_drop_o,
  output logic [NPORTS-1:0] first_stage_forward_ports_o,
  output logic [NPORTS-1:0] final_forward_ports_o,
  output logic [4:0] fwd_bufs_o,
  // buffer release
  input wire logic buf_free_i,
  input wire logic [4:0] buf_free_cnt_i,
  // flow control
  output logic [NPORTS-1:0] fc_xoff_o,
  output logic [NPORTS-1:0] pause_active_o,
  // mac transmit
  input wire logic tx_req_i,
  input wire logic tx_fc_frame_i,
  input wire logic [10:0] tx_bytes_i,
  output logic tx_done_o,
  output logic tx_drop_o,
  output logic port_transmit_enable_o,
  input wire logic port_carrier_sense_i,
  input wire logic port_collision_i
);
  localparam int IW = $clog2(TABLE_DEPTH);
  localparam int BW = $clog2(NUM_BUFS + 1);
  typedef enum logic [1:0] {L_IDLE, L_SCAN, L_DONE} lk_state_t;
  typedef enum logic [2:0] {M_IDLE, M_TX, M_BACKOFF, M_WAITCRS, M_IPG} mac_state_t;

  if (NPORTS < 2 || NPORTS > 4 || MAC_PORT >= NPORTS || TABLE_DEPTH < 2 ||
      TABLE_DEPTH > 4096 || NUM_BUFS < 32 || NUM_BUFS > 1023 || SEC_CYCLES < 1) begin : g_bad
    $error("switch_core: unsupported parameter values");
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // registers
  logic [4:0] ctrl;
  logic [NPORTS-1:0] fwd_mask;
  logic [15:0] mirror;
  logic [47:0] smac;
  logic [3:0] sports;
  logic svalid;
  logic [15:0] pvlan;
  logic bus_ack;
  logic [31:0] rd_val;
  logic [31:0] wd;
  logic bus_we;
  logic [BW-1:0] free_bufs;
  logic [IW:0] entries;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] be);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) merge[b*8 +: 8] = d[b*8 +: 8];
    end
  endfunction

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~bus_ack;
  assign bus_we = avs_write_i & bus_ack;
  assign wd = merge(rd_val, avs_writedata_i, avs_byteenable_i);

  always_comb begin
    rd_val = 32'h0000_0000;
    if (avs_address_i == sw_pkg::REG_CTRL) begin
      rd_val[4:0] = ctrl;
    end else if (avs_address_i == sw_pkg::REG_FWD_MASK) begin
      rd_val[NPORTS-1:0] = fwd_mask;
    end else if (avs_address_i == sw_pkg::REG_MIRROR) begin
      rd_val[15:0] = mirror;
    end else if (avs_address_i == sw_pkg::REG_STATUS) begin
      rd_val[BW-1:0] = free_bufs;
      rd_val[sw_pkg::STAT_ENTRIES +: IW+1] = entries;
    end else if (avs_address_i == sw_pkg::REG_SMAC_LO) begin
      rd_val = smac[31:0];
    end else if (avs_address_i == sw_pkg::REG_SMAC_HI) begin
      rd_val[15:0] = smac[47:32];
      rd_val[sw_pkg::SHI_PORTS +: 4] = sports;
      rd_val[sw_pkg::SHI_VALID] = svalid;
    end else if (avs_address_i == sw_pkg::REG_PVLAN) begin
      rd_val[15:0] = pvlan;
    end
  end

  // one wait state per access
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_ack <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      bus_ack <= (avs_read_i | avs_write_i) & ~bus_ack;
      if (avs_read_i & ~bus_ack) avs_readdata_o <= rd_val;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl <= sw_pkg::CTRL_RST;
      fwd_mask <= sw_pkg::FWD_MASK_RST[NPORTS-1:0];
      mirror <= sw_pkg::MIRROR_RST;
      smac <= 48'h0000_0000_0000;
      sports <= 4'h0;
      svalid <= 1'b0;
      pvlan <= sw_pkg::PVLAN_RST;
    end else if (bus_we) begin
      if (avs_address_i == sw_pkg::REG_CTRL) begin
        ctrl <= wd[4:0];
      end else if (avs_address_i == sw_pkg::REG_FWD_MASK) begin
        fwd_mask <= wd[NPORTS-1:0];
      end else if (avs_address_i == sw_pkg::REG_MIRROR) begin
        mirror <= wd[15:0];
      end else if (avs_address_i == sw_pkg::REG_SMAC_LO) begin
        smac[31:0] <= wd;
      end else if (avs_address_i == sw_pkg::REG_SMAC_HI) begin
        smac[47:32] <= wd[15:0];
        sports <= wd[sw_pkg::SHI_PORTS +: 4];
        svalid <= wd[sw_pkg::SHI_VALID];
      end else if (avs_address_i == sw_pkg::REG_PVLAN) begin
        pvlan <= wd[15:0];
      end
    end
  end

  // pin synchronisers, change taken when stages two and three agree
  logic [1:0] sy1, sy2, sy3, pin_f;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sy1 <= 2'h0;
      sy2 <= 2'h0;
      sy3 <= 2'h0;
      pin_f <= 2'h0;
    end else begin
      sy1 <= {port_collision_i, port_carrier_sense_i};
      sy2 <= sy1;
      sy3 <= sy2;
      pin_f <= (sy2 & sy3) | (pin_f & (sy2 ^ sy3));
    end
  end

  // nibble-time, pause-quantum and one-second enables
  logic [19:0] nib_acc, nib_ps;
  logic [19:0] nib_sum;
  logic nib_tick, q_tick, sec_tick;
  logic [6:0] q_cnt;
  logic [31:0] sec_cnt;
  logic [8:0] now_sec;
  assign nib_ps = ctrl[sw_pkg::CTRL_SPEED] ? 20'(sw_pkg::NIB_PS_100) : 20'(sw_pkg::NIB_PS_10);
  assign nib_sum = nib_acc + 20'(sw_pkg::CLK_PS);
  assign nib_tick = nib_sum >= nib_ps;
  assign q_tick = nib_tick && q_cnt == 7'(sw_pkg::QUANTUM_NIBS - 1);
  assign sec_tick = sec_cnt == 32'(SEC_CYCLES - 1);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nib_acc <= 20'h00000;
      q_cnt <= 7'h00;
      sec_cnt <= 32'h0000_0000;
      now_sec <= 9'h000;
    end else begin
      nib_acc <= nib_tick ? nib_sum - nib_ps : nib_sum;
      if (nib_tick) q_cnt <= q_cnt + 7'h01;
      sec_cnt <= sec_tick ? 32'h0000_0000 : sec_cnt + 32'h0000_0001;
      if (sec_tick) now_sec <= now_sec + 9'h001;
    end
  end

  // address table
  logic [47:0] t_mac [TABLE_DEPTH];
  logic [1:0] t_port [TABLE_DEPTH];
  logic [8:0] t_stamp [TABLE_DEPTH];
  logic [TABLE_DEPTH-1:0] t_valid;
  lk_state_t lstate;
  logic [IW-1:0] scan_idx, age_idx, sa_idx, free_idx, slot;
  logic [1:0] c_port, da_port;
  logic [47:0] c_sa, c_da;
  logic [10:0] c_len, max_len;
  logic [4:0] c_need, rx_need;
  logic c_igmp, c_bad, c_pause, sa_hit, da_hit, free_hit;
  logic rx_acc, size_bad, early, age_stale;
  assign rx_ready_o = lstate == L_IDLE;
  assign rx_acc = rx_valid_i && rx_ready_o;
  assign max_len = (ctrl[sw_pkg::CTRL_HUGE] ? 11'(sw_pkg::HUGE_FRAME) : 11'(sw_pkg::MAX_FRAME))
                   + (rx_tagged_i ? 11'(sw_pkg::VLAN_TAG_BYTES) : 11'h000);
  assign size_bad = rx_len_i < 11'(sw_pkg::MIN_FRAME) || rx_len_i > max_len;
  assign early = rx_err_i || size_bad || rx_pause_i;
  assign rx_need = 5'((12'(rx_len_i) + 12'(sw_pkg::BUF_BYTES - 1)) >> 7);
  assign slot = free_hit ? free_idx : IW'(TABLE_DEPTH - 1);
  assign age_stale = ctrl[sw_pkg::CTRL_AGE] && t_valid[age_idx] &&
                     9'(now_sec - t_stamp[age_idx]) >= 9'(sw_pkg::AGE_PERIOD_S);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lstate <= L_IDLE;
      scan_idx <= '0;
      c_port <= 2'h0;
      c_sa <= 48'h0000_0000_0000;
      c_da <= 48'h0000_0000_0000;
      c_len <= 11'h000;
      c_need <= 5'h00;
      c_igmp <= 1'b0;
      c_bad <= 1'b0;
      c_pause <= 1'b0;
    end else begin
      case (lstate)
        L_IDLE: if (rx_acc) begin
          c_port <= rx_port_i;
          c_sa <= rx_sa_i;
          c_da <= rx_da_i;
          c_len <= rx_len_i;
          c_need <= rx_need;
          c_igmp <= rx_igmp_i;
          c_bad <= rx_err_i | size_bad;
          c_pause <= rx_pause_i;
          scan_idx <= '0;
          if (!early) lstate <= L_SCAN;
        end
        L_SCAN: begin
          scan_idx <= scan_idx + 1'b1;
          if (scan_idx == IW'(TABLE_DEPTH - 1)) lstate <= L_DONE;
        end
        default: lstate <= L_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sa_hit <= 1'b0;
      da_hit <= 1'b0;
      free_hit <= 1'b0;
      sa_idx <= '0;
      free_idx <= '0;
      da_port <= 2'h0;
    end else if (rx_acc) begin
      sa_hit <= 1'b0;
      da_hit <= 1'b0;
      free_hit <= 1'b0;
    end else if (lstate == L_SCAN) begin
      if (t_valid[scan_idx] && t_mac[scan_idx] == c_sa && !sa_hit) begin
        sa_hit <= 1'b1;
        sa_idx <= scan_idx;
      end
      if (t_valid[scan_idx] && t_mac[scan_idx] == c_da && !da_hit) begin
        da_hit <= 1'b1;
        da_port <= t_port[scan_idx];
      end
      if (!t_valid[scan_idx] && !free_hit) begin
        free_hit <= 1'b1;
        free_idx <= scan_idx;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (lstate == L_DONE) begin
      if (sa_hit) begin
        t_port[sa_idx] <= c_port;
        t_stamp[sa_idx] <= now_sec;
      end else begin
        t_mac[slot] <= c_sa;
        t_port[slot] <= c_port;
        t_stamp[slot] <= now_sec;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      t_valid <= '0;
      entries <= '0;
      age_idx <= '0;
    end else if (lstate == L_DONE) begin
      if (!sa_hit) t_valid[slot] <= 1'b1;
      if (!sa_hit && free_hit) entries <= entries + 1'b1;
    end else if (lstate == L_IDLE) begin
      age_idx <= age_idx + 1'b1;
      if (age_stale) begin
        t_valid[age_idx] <= 1'b0;
        entries <= entries - 1'b1;
      end
    end
  end

  // port resolution
  logic [NPORTS-1:0] src_bit, first_stage_forward_ports_c, final_forward_ports_c, mir_dst, host;
  logic local_c, drop_c, busy_c, fc_busy;
  assign src_bit = NPORTS'(1) << c_port;
  assign mir_dst = mirror[sw_pkg::MIR_DST +: NPORTS];
  assign host = mirror[sw_pkg::MIR_HOST +: NPORTS];
  always_comb begin
    if (svalid && c_da == smac) begin
      first_stage_forward_ports_c = sports[NPORTS-1:0];
    end else if (c_da[40] || !da_hit) begin
      first_stage_forward_ports_c = {NPORTS{1'b1}};
    end else begin
      first_stage_forward_ports_c = NPORTS'(1) << da_port;
    end
    final_forward_ports_c = first_stage_forward_ports_c & pvlan[c_port*4 +: NPORTS] & fwd_mask;
    if (c_igmp && mirror[sw_pkg::MIR_IGMP]) final_forward_ports_c = host;
    if (mirror[sw_pkg::MIR_SRC + c_port]) final_forward_ports_c = final_forward_ports_c | mir_dst;
    final_forward_ports_c = fwd_mask[c_port] ? final_forward_ports_c & ~src_bit : '0;
  end
  assign local_c = first_stage_forward_ports_c == src_bit;
  assign drop_c = local_c || final_forward_ports_c == '0 || 10'(c_need) > 10'(free_bufs);
  assign busy_c = 10'(c_need) + 10'(sw_pkg::XOFF_LEVEL) > 10'(free_bufs);
  assign fc_busy = lstate == L_DONE && !local_c && final_forward_ports_c != '0 && busy_c;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fwd_valid_o <= 1'b0;
      fwd_drop_o <= 1'b0;
      first_stage_forward_ports_o <= '0;
      final_forward_ports_o <= '0;
      fwd_bufs_o <= 5'h00;
    end else begin
      fwd_valid_o <= (rx_acc && early) || lstate == L_DONE;
      if (rx_acc && early) begin
        fwd_drop_o <= 1'b1;
        first_stage_forward_ports_o <= '0;
        final_forward_ports_o <= '0;
        fwd_bufs_o <= 5'h00;
      end else if (lstate == L_DONE) begin
        fwd_drop_o <= drop_c;
        first_stage_forward_ports_o <= first_stage_forward_ports_c;
        final_forward_ports_o <= drop_c ? '0 : final_forward_ports_c;
        fwd_bufs_o <= drop_c ? 5'h00 : c_need;
      end
    end
  end

  // shared buffer pool
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      free_bufs <= BW'(NUM_BUFS);
    end else begin
      free_bufs <= free_bufs + (buf_free_i ? BW'(buf_free_cnt_i) : BW'(0))
                   - (lstate == L_DONE && !drop_c ? BW'(c_need) : BW'(0));
    end
  end

  // per-port pause timers and flow control
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic [15:0] pause_tmr;
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        pause_tmr <= 16'h0000;
      end else if (rx_acc && rx_pause_i && !rx_err_i && rx_port_i == 2'(p)) begin
        pause_tmr <= rx_pause_time_i;
      end else if (q_tick && pause_tmr != 16'h0000) begin
        pause_tmr <= pause_tmr - 16'h0001;
      end
    end
    assign pause_active_o[p] = pause_tmr != 16'h0000;
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        fc_xoff_o[p] <= 1'b0;
      end else if (free_bufs == '0 || (fc_busy && c_port == 2'(p))) begin
        fc_xoff_o[p] <= 1'b1;
      end else if (10'(free_bufs) >= 10'(sw_pkg::XON_LEVEL)) begin
        fc_xoff_o[p] <= 1'b0;
      end
    end
  end

  // mac transmit timing
  mac_state_t mstate;
  logic [16:0] nib_cnt;
  logic [11:0] len_nibs;
  logic [4:0] coll_n;
  logic [9:0] lfsr;
  logic [4:0] bo_k;
  logic [10:0] bo_span;
  assign bo_k = (coll_n + 5'h01) > (ctrl[sw_pkg::CTRL_AGGR] ? 5'(sw_pkg::BO_AGGR_LIMIT) :
                5'(sw_pkg::BO_LIMIT)) ? (ctrl[sw_pkg::CTRL_AGGR] ? 5'(sw_pkg::BO_AGGR_LIMIT) :
                5'(sw_pkg::BO_LIMIT)) : coll_n + 5'h01;
  assign bo_span = (11'h001 << bo_k) - 11'h001;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mstate <= M_IDLE;
      nib_cnt <= 17'h00000;
      len_nibs <= 12'h000;
      coll_n <= 5'h00;
      lfsr <= 10'h001;
      port_transmit_enable_o <= 1'b0;
      tx_done_o <= 1'b0;
      tx_drop_o <= 1'b0;
    end else begin
      lfsr <= {lfsr[8:0], lfsr[9] ^ lfsr[6]};
      tx_done_o <= 1'b0;
      tx_drop_o <= 1'b0;
      case (mstate)
        M_IDLE: if (tx_req_i && (!pause_active_o[MAC_PORT] || tx_fc_frame_i)) begin
          mstate <= M_TX;
          port_transmit_enable_o <= 1'b1;
          nib_cnt <= 17'h00000;
          len_nibs <= {tx_bytes_i, 1'b0};
        end
        M_TX: if (pin_f[1]) begin
          port_transmit_enable_o <= 1'b0;
          if (nib_cnt >= 17'(sw_pkg::SLOT_NIBS)) begin
            tx_drop_o <= 1'b1;
            coll_n <= 5'h00;
            mstate <= M_WAITCRS;
          end else if (coll_n == 5'(sw_pkg::MAX_COLL - 1) && ctrl[sw_pkg::CTRL_XDROP]) begin
            tx_drop_o <= 1'b1;
            coll_n <= 5'h00;
            mstate <= M_WAITCRS;
          end else begin
            coll_n <= coll_n == 5'(sw_pkg::MAX_COLL - 1) ? 5'h00 : coll_n + 5'h01;
            nib_cnt <= {6'h00, lfsr & bo_span[9:0], 1'b0} << 6;
            mstate <= M_BACKOFF;
          end
        end else if (nib_tick) begin
          if (nib_cnt + 17'h00001 == 17'(len_nibs)) begin
            port_transmit_enable_o <= 1'b0;
            tx_done_o <= 1'b1;
            coll_n <= 5'h00;
            nib_cnt <= 17'h00000;
            mstate <= M_IPG;
          end else begin
            nib_cnt <= nib_cnt + 17'h00001;
          end
        end
        M_BACKOFF: if (nib_cnt == 17'h00000) begin
          mstate <= M_WAITCRS;
        end else if (nib_tick) begin
          nib_cnt <= nib_cnt - 17'h00001;
        end
        M_WAITCRS: if (!pin_f[0]) begin
          nib_cnt <= 17'h00000;
          mstate <= M_IPG;
        end
        default: if (nib_tick) begin
          nib_cnt <= nib_cnt + 17'h00001;
          if (nib_cnt == 17'(sw_pkg::IPG_NIBS - 1)) mstate <= M_IDLE;
        end
      endcase
    end
  end

  // assertion helpers: gap counters in nibble times
  logic [5:0] gap_tx, gap_crs;
  logic ever_tx, after_col;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gap_tx <= 6'h00;
      gap_crs <= 6'h00;
      ever_tx <= 1'b0;
      after_col <= 1'b0;
    end else begin
      gap_tx <= port_transmit_enable_o ? 6'h00 : gap_tx + 6'(nib_tick && gap_tx != 6'h3F);
      gap_crs <= (port_transmit_enable_o || pin_f[0]) ? 6'h00 :
                 gap_crs + 6'(nib_tick && gap_crs != 6'h3F);
      if (port_transmit_enable_o) ever_tx <= 1'b1;
      if (mstate == M_TX && pin_f[1]) after_col <= 1'b1;
      else if (tx_done_o) after_col <= 1'b0;
    end
  end

  sequence s_late_col;
    mstate == M_TX && pin_f[1] && nib_cnt >= 17'(sw_pkg::SLOT_NIBS);
  endsequence
  sequence s_new_frame;
    lstate == L_DONE && !sa_hit && free_hit;
  endsequence

  chk_learn_count: assert property (s_new_frame |=> entries == $past(entries) + 1'b1)
    else $error("learned entry not counted");
  chk_full_replace: assert property (lstate == L_DONE && !sa_hit && !free_hit |=>
    t_valid[TABLE_DEPTH-1] && entries == $past(entries))
    else $error("full table did not reuse last slot");
  chk_error_drop: assert property (fwd_valid_o && c_bad |->
    fwd_drop_o && final_forward_ports_o == '0)
    else $error("errored frame forwarded");
  chk_pause_drop: assert property (fwd_valid_o && c_pause |->
    fwd_drop_o && final_forward_ports_o == '0)
    else $error("pause frame forwarded");
  chk_local_drop: assert property (lstate == L_DONE && da_hit && da_port == c_port && !c_da[40] &&
    !(svalid && c_da == smac) |=> fwd_valid_o && fwd_drop_o)
    else $error("local frame forwarded");
  chk_short_drop: assert property (fwd_valid_o && c_len < 11'(sw_pkg::MIN_FRAME) |-> fwd_drop_o)
    else $error("runt frame forwarded");
  chk_ipg_success: assert property ($rose(port_transmit_enable_o) && $past(ever_tx) |->
    $past(gap_tx) >= 6'(sw_pkg::IPG_NIBS))
    else $error("gap after transmit too short");
  chk_ipg_collision: assert property ($rose(port_transmit_enable_o) && after_col |->
    $past(gap_crs) >= 6'(sw_pkg::IPG_NIBS))
    else $error("gap after carrier too short");
  chk_late_drop: assert property (s_late_col |=> tx_drop_o && !port_transmit_enable_o ##1
    mstate != M_TX)
    else $error("late collision not dropped");
  chk_pause_hold: assert property ($rose(port_transmit_enable_o) && $past(pause_active_o[MAC_PORT])
    |-> $past(tx_fc_frame_i))
    else $error("normal frame sent while paused");
  chk_full_fc: assert property (free_bufs == '0 |=> fc_xoff_o == {NPORTS{1'b1}})
    else $error("full queue did not flow control all ports");
endmodule

//--- verif/link_partner.sv
`timescale 1ns/1ps
module link_partner (
  // mac side
  input wire logic clk_i,
  input wire logic port_transmit_enable_i,
  input wire logic coll_req_i,
  // line indications
  output logic port_carrier_sense_o,
  output logic port_collision_o
);
  always_ff @(posedge clk_i) begin
    port_carrier_sense_o <= port_transmit_enable_i | port_collision_o;
    port_collision_o <= port_transmit_enable_i & coll_req_i;
  end
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_i = 0, nrst_i = 0, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o;
  logic rx_valid_i = 0, rx_err_i = 0, rx_tagged_i = 0, rx_pause_i = 0, rx_ready_o;
  logic [7:0] avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [1:0] rx_port_i = 2'h0;
  logic [47:0] rx_sa_i = 48'h0, rx_da_i = 48'h0;
  logic [10:0] rx_len_i = 11'h040, tx_bytes_i = 11'h064;
  logic coll_req = 0, buf_free_i = 0;
  logic [4:0] buf_free_cnt_i = 5'h00;
  int fb = sw_pkg::NUM_BUFS;
  logic [15:0] rx_pause_time_i = 16'h0000;
  logic [3:0] first_stage_forward_ports_o, final_forward_ports_o, fc_xoff_o, pause_active_o;
  logic [4:0] fwd_bufs_o;
  logic fwd_valid_o, fwd_drop_o, tx_req_i = 0, tx_done_o, tx_drop_o, port_transmit_enable_o;
  logic port_carrier_sense_i, port_collision_i, en_q = 0, seen = 0;
  int mismatches = 0, checks_done = 0, n, gap = 0, k;
  logic [1:0] t[logic [47:0]];
  switch_core #(.TABLE_DEPTH(16), .SEC_CYCLES(100)) uut (.clk_i, .nrst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o,
    .avs_waitrequest_o, .rx_valid_i, .rx_ready_o, .rx_port_i, .rx_sa_i, .rx_da_i, .rx_len_i,
    .rx_err_i, .rx_tagged_i, .rx_pause_i, .rx_pause_time_i, .rx_igmp_i(1'b0), .fwd_valid_o,
    .fwd_drop_o, .first_stage_forward_ports_o, .final_forward_ports_o, .fwd_bufs_o,
    .buf_free_i, .buf_free_cnt_i, .fc_xoff_o, .pause_active_o, .tx_req_i,
    .tx_fc_frame_i(1'b0), .tx_bytes_i, .tx_done_o, .tx_drop_o, .port_transmit_enable_o,
    .port_carrier_sense_i, .port_collision_i);
  link_partner lp (.clk_i, .port_transmit_enable_i(port_transmit_enable_o),
    .coll_req_i(coll_req), .port_carrier_sense_o(port_carrier_sense_i),
    .port_collision_o(port_collision_i));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t seen %0h expected %0h", $time, s, e);
    end
  endtask
  task hang;
    mismatches++;
    print_verdict;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (n == 50) hang;
    q = avs_readdata_o;
    avs_read_i <= 0;
    avs_write_i <= 0;
  endtask
  task send(input logic [1:0] p, logic [47:0] sa, da, logic [10:0] len, logic e, g, ps,
            logic [15:0] pt);
    logic x, early;
    for (n = 0; n < 99 && rx_ready_o !== 1'b1; n++) @(negedge clk_i);
    if (n == 99) hang;
    @(posedge clk_i);
    {rx_port_i, rx_sa_i, rx_da_i, rx_len_i} <= {p, sa, da, len};
    {rx_err_i, rx_tagged_i, rx_pause_i, rx_pause_time_i, rx_valid_i} <= {e, g, ps, pt, 1'b1};
    @(posedge clk_i);
    rx_valid_i <= 0;
    for (n = 0; n < 99 && fwd_valid_o !== 1'b1; n++) @(negedge clk_i);
    if (n == 99) hang;
    early = e | ps | (len < sw_pkg::MIN_FRAME) |
      (len > sw_pkg::MAX_FRAME + (g ? sw_pkg::VLAN_TAG_BYTES : 0));
    x = early | (t.exists(da) && t[da] == p);
    chk(fwd_drop_o, x);
    if (!x && t.exists(da)) chk(first_stage_forward_ports_o, 4'h1 << t[da]);
    chk(fwd_bufs_o, x ? 0 : (len + sw_pkg::BUF_BYTES - 1) / sw_pkg::BUF_BYTES);
    if (!x) fb -= (len + sw_pkg::BUF_BYTES - 1) / sw_pkg::BUF_BYTES;
    if (ps && pt != 0) chk(pause_active_o[p], 1);
    if (!early) t[sa] = p;
  endtask
  always @(posedge clk_i) begin
    if (port_transmit_enable_o && !en_q && seen) chk(gap >= 37, 1);
    if (port_transmit_enable_o) seen = 1;
    gap = port_transmit_enable_o ? 0 : gap + 1;
    en_q = port_transmit_enable_o;
  end
  initial begin
    void'($urandom(32'h178E));
    repeat (6) @(posedge clk_i);
    nrst_i <= 1;
    bus(0, sw_pkg::REG_CTRL, 0);
    chk(q, 32'(sw_pkg::CTRL_RST));
    bus(0, 8'h1C, 0);
    chk(q, 0);
    for (int i = 0; i < 24; i++) begin
      k = $urandom % 8;
      send(2'($urandom), 48'($urandom % 4), 48'($urandom % 5),
        k == 1 ? 11'd63 : k == 2 ? 11'd1541 : 11'd64 + 11'($urandom % 99),
        k == 3, 1'($urandom), k == 4, 16'(1 + $urandom % 3));
    end
    k = $urandom % 8;
    if (k > sw_pkg::NUM_BUFS - fb) k = sw_pkg::NUM_BUFS - fb;
    @(posedge clk_i);
    buf_free_i <= 1;
    buf_free_cnt_i <= 5'(k);
    @(posedge clk_i);
    buf_free_i <= 0;
    fb += k;
    bus(0, sw_pkg::REG_STATUS, 0);
    chk(q[9:0], fb);
    chk(q[26:16], t.num());
    chk(fc_xoff_o, 0);
    send(0, 48'h9, 48'h5, 11'd64, 0, 0, 1, 16'h0002);
    @(posedge clk_i);
    tx_req_i <= 1;
    for (k = 0; k < 3000 && pause_active_o[0] === 1'b1; k++) begin
      @(negedge clk_i);
      chk(port_transmit_enable_o, 0);
    end
    for (int j = 0; j < 3; j++) begin
      @(posedge clk_i);
      tx_req_i <= 1;
      for (k = 0; k < 200 && port_transmit_enable_o !== 1'b1; k++) @(negedge clk_i);
      if (k == 200) hang;
      if (j == 2) repeat (250) @(posedge clk_i);
      if (j > 0) begin
        @(posedge clk_i);
        coll_req <= 1;
        repeat (6) @(posedge clk_i);
        coll_req <= 0;
      end
      for (k = 0; k < 900 && tx_done_o !== 1'b1 && tx_drop_o !== 1'b1; k++) @(negedge clk_i);
      if (k == 900) hang;
      chk(tx_drop_o, j == 2);
      chk(tx_done_o, j != 2);
      @(posedge clk_i);
      tx_req_i <= 0;
    end
    repeat (30300) @(posedge clk_i);
    bus(0, sw_pkg::REG_STATUS, 0);
    chk(q[26:16], 0);
    bus(1, sw_pkg::REG_MIRROR, 32'h0000_A5C3);
    bus(0, sw_pkg::REG_MIRROR, 0);
    chk(q, 32'h0000_A5C3);
    print_verdict;
  end
endmodule
